// File: dmsm_pkg.sv
package dmsm_pkg;
	// Clock and timebase
	localparam int CLK_HZ = 10000000;
	localparam int TICK_MS = 50;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam logic [4:0] TICKS_PER_S = 5'(1000 / TICK_MS);
	// Qualification times in seconds
	localparam logic [15:0] LOCK_QUAL_S = 16'h0002;
	localparam logic [15:0] INVALID_S = 16'h0002;
	localparam logic [15:0] TIMEOUT_RST = 16'h0064;
	// Averager periods in seconds and filter shifts
	localparam logic [12:0] SHORT_AVG_S = 13'h01E0;
	localparam logic [12:0] LONG_AVG_S = 13'h19C8;
	localparam int SHORT_SHIFT = 7;
	localparam int LONG_SHIFT = 11;
	localparam int RATE_W = 19;
	// Register byte offsets
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_TIMEOUT = 6'h04;
	localparam logic [5:0] OFS_HOLD_RATE = 6'h08;
	localparam logic [5:0] OFS_GAP_RATE = 6'h0C;
	localparam logic [5:0] OFS_ACQ_BW = 6'h10;
	localparam logic [5:0] OFS_LOCK_BW = 6'h14;
	localparam logic [5:0] OFS_FORCE = 6'h18;
	localparam logic [5:0] OFS_STATUS = 6'h1C;
	localparam logic [5:0] OFS_VALID = 6'h20;
	localparam logic [5:0] OFS_ALARM = 6'h24;
	localparam logic [5:0] OFS_EVENTS = 6'h28;
	// Control register fields
	localparam int C_REVERTIVE_ENABLE = 0;
	localparam int C_LOCK_OUTPUT_ENABLE = 1;
	localparam int C_FREE_RUN_HOLDOVER_SELECT = 2;
	localparam int C_AVG = 3;
	localparam int C_MANUAL = 4;
	localparam int C_SHORT = 5;
	localparam int C_AVERAGED_READBACK_SELECT = 6;
	localparam int C_BANDWIDTH_AUTO_SWITCH = 7;
	localparam int C_CLAMP = 8;
	localparam logic [8:0] CTRL_RST = 9'h001;
	// Event register fields
	localparam int E_STATE = 0;
	localparam int E_SHORT_RDY = 1;
	localparam int E_LONG_RDY = 2;
	// Bandwidth reset codes
	localparam logic [7:0] ACQ_BW_RST = 8'h10;
	localparam logic [7:0] LOCK_BW_RST = 8'h08;
	// Mode states
	typedef enum logic [2:0] {
		ST_FREE, ST_PRE, ST_PRE2, ST_LOCKED, ST_LOL, ST_HOLD
	} dmsm_state_e;
endpackage : dmsm_pkg

// File: dmsm_timebase.sv
`timescale 1ns/10ps
`default_nettype none
module dmsm_timebase #(
	parameter int TICK_CYC = dmsm_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Timebase pulses
	output logic tick,
	output logic secTick
);
	logic [19:0] cycCnt_reg;
	logic [4:0] tickCnt_reg;

	// Fractional-second tick divider
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cycCnt_reg <= 20'h00000;
			tick <= 1'b0;
		end
		else if (cycCnt_reg == 20'(TICK_CYC - 1))
		begin
			cycCnt_reg <= 20'h00000;
			tick <= 1'b1;
		end
		else
		begin
			cycCnt_reg <= cycCnt_reg + 20'h00001;
			tick <= 1'b0;
		end
	end

	// Seconds divider
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			tickCnt_reg <= 5'h00;
			secTick <= 1'b0;
		end
		else
		begin
			secTick <= 1'b0;
			if (tick)
			begin
				if (tickCnt_reg == dmsm_pkg::TICKS_PER_S - 5'h01)
				begin
					tickCnt_reg <= 5'h00;
					secTick <= 1'b1;
				end
				else
					tickCnt_reg <= tickCnt_reg + 5'h01;
			end
		end
	end
endmodule : dmsm_timebase
`default_nettype wire

// File: dmsm_averager.sv
`timescale 1ns/10ps
`default_nettype none
module dmsm_averager #(
	parameter int SHIFT = dmsm_pkg::SHORT_SHIFT,
	parameter logic [12:0] PERIOD_S = dmsm_pkg::SHORT_AVG_S
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Samples, one per locked second
	input wire logic sampleEn,
	input wire logic [18:0] rate,
	// Averaged value
	output logic [18:0] averaged_holdover_select,
	output logic ready
);
	localparam int AW = 19 + SHIFT;
	logic signed [AW-1:0] acc_reg;
	logic [12:0] count_reg;
	logic signed [AW-1:0] sampleExt;

	assign sampleExt = AW'(signed'(rate));

	// Leaky integrator, seeded by the first sample
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			acc_reg <= '0;
			count_reg <= 13'h0000;
			ready <= 1'b0;
			averaged_holdover_select <= 19'h00000;
		end
		else if (sampleEn)
		begin
			if (count_reg == 13'h0000)
				acc_reg <= sampleExt <<< SHIFT;
			else
				acc_reg <= acc_reg - (acc_reg >>> SHIFT) + sampleExt;
			if (count_reg != PERIOD_S)
				count_reg <= count_reg + 13'h0001;
			else
				ready <= 1'b1; // Full period seen
			averaged_holdover_select <= acc_reg[AW-1:SHIFT];
		end
	end
endmodule : dmsm_averager
`default_nettype wire

// File: dmsm_core.sv
`timescale 1ns/10ps
`default_nettype none
module dmsm_core #(
	parameter int TICK_CYC = dmsm_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Avalon-MM slave
	input wire logic [5:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	// Monitors and loop
	input wire logic [7:0] inputOk,
	input wire logic phaseLocked,
	input wire logic lossOfLock,
	input wire logic fastIsolate,
	input wire logic freqAtLimit,
	input wire logic [18:0] integralRate,
	// Loop control outputs
	output logic lock_output_enable,
	output logic [2:0] dpllState,
	output logic [2:0] selectedRef,
	output logic freeRunMode,
	output logic holdoverMode,
	output logic miniHoldover,
	output logic [18:0] holdRate,
	output logic [7:0] loopBandwidth,
	output logic integralFreeze
);
	dmsm_pkg::dmsm_state_e state_reg, stateNext;
	logic [8:0] ctrl_reg;
	logic [15:0] timeout_reg;
	logic [18:0] holdWord_reg, gapWord_reg;
	logic [7:0] acqBw_reg, lockBw_reg;
	logic [7:0] alarm_reg;
	logic [2:0] events_reg;
	logic [2:0] selRef_reg;
	logic [15:0] windowSec_reg, lockSec_reg, invalidSec_reg;
	logic [18:0] instNew_reg, instOld_reg;
	logic [2:0] miniRef_reg;
	logic tick, secTick;
	logic [18:0] shortAvg, longAvg;
	logic shortRdy, longRdy, shortRdyQ_reg, longRdyQ_reg;
	logic [7:0] validFlag;
	logic anyValid, selValid, higherValid, reenter, raiseAlarm;
	logic restart, wrAck, rdAck, forceWr;
	logic [2:0] bestRef;

	// Highest priority valid input: lowest index wins
	function automatic logic [2:0] best_of(input logic [7:0] v);
		logic [2:0] b;
		b = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (v[i])
				b = 3'(i);
		return b;
	endfunction : best_of

	////////////////////////////////////////////////////////////////////////
	// Timebase and averagers

	dmsm_timebase #(.TICK_CYC(TICK_CYC)) uTimebase (
		.mclk(mclk),
		.resetn(resetn),
		.tick(tick),
		.secTick(secTick)
	);

	dmsm_averager #(
		.SHIFT(dmsm_pkg::SHORT_SHIFT),
		.PERIOD_S(dmsm_pkg::SHORT_AVG_S)
	) uShortAvg (
		.mclk(mclk),
		.resetn(resetn),
		.sampleEn(secTick && state_reg == dmsm_pkg::ST_LOCKED),
		.rate(integralRate),
		.averaged_holdover_select(shortAvg),
		.ready(shortRdy)
	);

	dmsm_averager #(
		.SHIFT(dmsm_pkg::LONG_SHIFT),
		.PERIOD_S(dmsm_pkg::LONG_AVG_S)
	) uLongAvg (
		.mclk(mclk),
		.resetn(resetn),
		.sampleEn(secTick && state_reg == dmsm_pkg::ST_LOCKED),
		.rate(integralRate),
		.averaged_holdover_select(longAvg),
		.ready(longRdy)
	);

	////////////////////////////////////////////////////////////////////////
	// Input validity and selection

	// Valid means monitors clean and no phase-lock alarm
	assign validFlag = inputOk & ~alarm_reg;
	assign anyValid = |validFlag;
	assign selValid = validFlag[selRef_reg];
	assign bestRef = best_of(validFlag);
	assign higherValid = anyValid && (bestRef < selRef_reg);
	assign wrAck = avsWrite && !avsWaitRequest;
	assign rdAck = avsRead && avsWaitRequest;
	assign forceWr = wrAck && avsAddress == dmsm_pkg::OFS_FORCE
		&& avsWriteData[2:0] <= 3'(dmsm_pkg::ST_HOLD);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	// Transitions, re-entry and timeout alarm
	always_comb
	begin
		stateNext = state_reg;
		reenter = 1'b0;
		raiseAlarm = 1'b0;
		case (state_reg)
			dmsm_pkg::ST_FREE:
				if (anyValid)
					stateNext = dmsm_pkg::ST_PRE;
			dmsm_pkg::ST_PRE, dmsm_pkg::ST_PRE2:
				if (selValid && lockSec_reg >= dmsm_pkg::LOCK_QUAL_S)
					stateNext = dmsm_pkg::ST_LOCKED;
				else if (selValid && ctrl_reg[dmsm_pkg::C_REVERTIVE_ENABLE]
					&& higherValid)
					reenter = 1'b1;
				else if (!selValid && anyValid)
					reenter = 1'b1;
				else if (!selValid
					&& invalidSec_reg >= dmsm_pkg::INVALID_S)
					stateNext = (state_reg == dmsm_pkg::ST_PRE) ?
						dmsm_pkg::ST_FREE : dmsm_pkg::ST_HOLD;
				else if (selValid && windowSec_reg >= timeout_reg)
					raiseAlarm = 1'b1;
			dmsm_pkg::ST_LOCKED:
				if (!selValid && anyValid)
					stateNext = dmsm_pkg::ST_PRE2;
				else if (!selValid
					&& invalidSec_reg >= dmsm_pkg::INVALID_S)
					stateNext = dmsm_pkg::ST_HOLD;
				else if (selValid && lossOfLock)
					stateNext = dmsm_pkg::ST_LOL;
			dmsm_pkg::ST_LOL:
				if (selValid && lockSec_reg >= dmsm_pkg::LOCK_QUAL_S)
					stateNext = dmsm_pkg::ST_LOCKED;
				else if (!selValid && anyValid && raiseAlarm == 1'b0
					&& alarm_reg[selRef_reg])
					stateNext = dmsm_pkg::ST_PRE2;
				else if (!selValid
					&& invalidSec_reg >= dmsm_pkg::INVALID_S)
					stateNext = anyValid ? dmsm_pkg::ST_PRE2 :
						dmsm_pkg::ST_HOLD;
				else if (selValid && windowSec_reg >= timeout_reg)
					raiseAlarm = 1'b1;
			dmsm_pkg::ST_HOLD:
				if (anyValid)
					stateNext = dmsm_pkg::ST_PRE2;
			default:
				stateNext = dmsm_pkg::ST_FREE;
		endcase
	end

	assign restart = reenter || stateNext != state_reg;

	// State register with software force
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			state_reg <= dmsm_pkg::ST_FREE;
		else if (forceWr)
			state_reg <= dmsm_pkg::dmsm_state_e'(avsWriteData[2:0]);
		else
			state_reg <= stateNext;
	end

	// Reference selection on entry or re-entry
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			selRef_reg <= 3'h0;
		else if (restart && anyValid
			&& (stateNext == dmsm_pkg::ST_PRE
			|| stateNext == dmsm_pkg::ST_PRE2))
			selRef_reg <= bestRef;
	end

	////////////////////////////////////////////////////////////////////////
	// Second counters

	// Window, lock and invalid durations
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			windowSec_reg <= 16'h0000;
			lockSec_reg <= 16'h0000;
			invalidSec_reg <= 16'h0000;
		end
		else
		begin
			if (restart || forceWr)
				windowSec_reg <= 16'h0000;
			else if (secTick && windowSec_reg != 16'hFFFF)
				windowSec_reg <= windowSec_reg + 16'h0001;
			if (restart || forceWr || !phaseLocked)
				lockSec_reg <= 16'h0000;
			else if (secTick && lockSec_reg != 16'hFFFF)
				lockSec_reg <= lockSec_reg + 16'h0001;
			if (selValid || restart)
				invalidSec_reg <= 16'h0000;
			else if (secTick && invalidSec_reg != 16'hFFFF)
				invalidSec_reg <= invalidSec_reg + 16'h0001;
		end
	end

	// Phase-lock alarms, write one to clear, set wins
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			alarm_reg <= 8'h00;
		else
		begin
			for (int i = 0; i < 8; i++)
				if (raiseAlarm && selRef_reg == 3'(i))
					alarm_reg[i] <= 1'b1;
				else if (wrAck && avsAddress == dmsm_pkg::OFS_ALARM
					&& avsWriteData[i])
					alarm_reg[i] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Holdover frequency

	// Two-stage sample: old copy is 50 to 100 ms old
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			instNew_reg <= 19'h00000;
			instOld_reg <= 19'h00000;
		end
		else if (tick && state_reg != dmsm_pkg::ST_HOLD)
		begin
			instNew_reg <= integralRate;
			instOld_reg <= instNew_reg;
		end
	end

	// Mini-holdover tracks isolation of one reference
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			miniHoldover <= 1'b0;
			miniRef_reg <= 3'h0;
		end
		else if (stateNext == dmsm_pkg::ST_HOLD || !fastIsolate
			|| (miniHoldover && miniRef_reg != selRef_reg)
			|| state_reg == dmsm_pkg::ST_FREE)
			miniHoldover <= 1'b0;
		else if (!miniHoldover)
		begin
			miniHoldover <= 1'b1;
			miniRef_reg <= selRef_reg;
		end
	end

	// Holdover rate chosen at entry, live in mini-holdover
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			holdRate <= 19'h00000;
		else if (stateNext == dmsm_pkg::ST_HOLD
			&& state_reg != dmsm_pkg::ST_HOLD)
		begin
			if (ctrl_reg[dmsm_pkg::C_MANUAL])
				holdRate <= holdWord_reg;
			else if (ctrl_reg[dmsm_pkg::C_FREE_RUN_HOLDOVER_SELECT])
				holdRate <= 19'h00000;
			else if (!ctrl_reg[dmsm_pkg::C_AVG])
				holdRate <= instOld_reg;
			else if (!ctrl_reg[dmsm_pkg::C_SHORT] && longRdy)
				holdRate <= longAvg;
			else if (shortRdy)
				holdRate <= shortAvg;
			else
				holdRate <= instOld_reg;
		end
		else if (state_reg != dmsm_pkg::ST_HOLD && fastIsolate)
			holdRate <= ctrl_reg[dmsm_pkg::C_MANUAL] ?
				holdWord_reg : gapWord_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// Loop and pin outputs

	// Mode indicators, lock pin, bandwidth and clamp
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			lock_output_enable <= 1'b0;
			dpllState <= 3'h0;
			selectedRef <= 3'h0;
			freeRunMode <= 1'b1;
			holdoverMode <= 1'b0;
			loopBandwidth <= dmsm_pkg::LOCK_BW_RST;
			integralFreeze <= 1'b0;
		end
		else
		begin
			lock_output_enable <= ctrl_reg[dmsm_pkg::C_LOCK_OUTPUT_ENABLE]
				&& state_reg == dmsm_pkg::ST_LOCKED;
			dpllState <= 3'(state_reg);
			selectedRef <= selRef_reg;
			freeRunMode <= state_reg == dmsm_pkg::ST_FREE;
			holdoverMode <= state_reg == dmsm_pkg::ST_HOLD;
			loopBandwidth <= (ctrl_reg[dmsm_pkg::C_BANDWIDTH_AUTO_SWITCH]
				&& state_reg != dmsm_pkg::ST_LOCKED) ?
				acqBw_reg : lockBw_reg;
			integralFreeze <= ctrl_reg[dmsm_pkg::C_CLAMP]
				&& freqAtLimit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file

	// Latched events, write one to clear, set wins
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			events_reg <= 3'h0;
			shortRdyQ_reg <= 1'b0;
			longRdyQ_reg <= 1'b0;
		end
		else
		begin
			shortRdyQ_reg <= shortRdy;
			longRdyQ_reg <= longRdy;
			if (wrAck && avsAddress == dmsm_pkg::OFS_EVENTS)
				events_reg <= events_reg & ~avsWriteData[2:0];
			if (stateNext != state_reg || forceWr)
				events_reg[dmsm_pkg::E_STATE] <= 1'b1;
			if (shortRdy && !shortRdyQ_reg)
				events_reg[dmsm_pkg::E_SHORT_RDY] <= 1'b1;
			if (longRdy && !longRdyQ_reg)
				events_reg[dmsm_pkg::E_LONG_RDY] <= 1'b1;
		end
	end

	// Configuration writes
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_reg <= dmsm_pkg::CTRL_RST;
			timeout_reg <= dmsm_pkg::TIMEOUT_RST;
			holdWord_reg <= 19'h00000;
			gapWord_reg <= 19'h00000;
			acqBw_reg <= dmsm_pkg::ACQ_BW_RST;
			lockBw_reg <= dmsm_pkg::LOCK_BW_RST;
		end
		else if (wrAck)
		begin
			case (avsAddress)
				dmsm_pkg::OFS_CTRL: ctrl_reg <= avsWriteData[8:0];
				dmsm_pkg::OFS_TIMEOUT: timeout_reg <= avsWriteData[15:0];
				dmsm_pkg::OFS_HOLD_RATE: holdWord_reg <= avsWriteData[18:0];
				dmsm_pkg::OFS_GAP_RATE: gapWord_reg <= avsWriteData[18:0];
				dmsm_pkg::OFS_ACQ_BW: acqBw_reg <= avsWriteData[7:0];
				dmsm_pkg::OFS_LOCK_BW: lockBw_reg <= avsWriteData[7:0];
				default: ;
			endcase
		end
	end

	// One wait cycle per access, read data registered
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			avsWaitRequest <= 1'b1;
			avsReadData <= 32'h00000000;
		end
		else
		begin
			avsWaitRequest <= !((avsRead || avsWrite) && avsWaitRequest);
			if (rdAck)
			begin
				case (avsAddress)
					dmsm_pkg::OFS_CTRL: avsReadData <= {23'h0, ctrl_reg};
					dmsm_pkg::OFS_TIMEOUT: avsReadData <= {16'h0, timeout_reg};
					dmsm_pkg::OFS_HOLD_RATE:
						if (ctrl_reg[dmsm_pkg::C_AVERAGED_READBACK_SELECT])
							avsReadData <= {13'h0, ctrl_reg[dmsm_pkg::C_SHORT] ?
								shortAvg : longAvg};
						else
							avsReadData <= {13'h0, holdWord_reg};
					dmsm_pkg::OFS_GAP_RATE: avsReadData <= {13'h0, gapWord_reg};
					dmsm_pkg::OFS_ACQ_BW: avsReadData <= {24'h0, acqBw_reg};
					dmsm_pkg::OFS_LOCK_BW: avsReadData <= {24'h0, lockBw_reg};
					dmsm_pkg::OFS_STATUS:
						avsReadData <= {23'h0, longRdy, shortRdy, miniHoldover,
							selRef_reg, 3'(state_reg)};
					dmsm_pkg::OFS_VALID: avsReadData <= {24'h0, validFlag};
					dmsm_pkg::OFS_ALARM: avsReadData <= {24'h0, alarm_reg};
					dmsm_pkg::OFS_EVENTS: avsReadData <= {29'h0, events_reg};
					default: avsReadData <= 32'h00000000;
				endcase
			end
		end
	end
endmodule : dmsm_core
`default_nettype wire

// File: dmsm_core_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dmsm_core_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Monitors
	input wire logic [7:0] inputOk,
	input wire logic phaseLocked,
	input wire logic lossOfLock,
	input wire logic fastIsolate,
	input wire logic freqAtLimit,
	// Loop control
	input wire logic lock_output_enable,
	input wire logic [2:0] dpllState,
	input wire logic freeRunMode,
	input wire logic holdoverMode,
	input wire logic miniHoldover,
	input wire logic integralFreeze
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// State flags and pin agree with the state code
	property p_lock_pin;
		lock_output_enable |-> dpllState == dmsm_pkg::ST_LOCKED;
	endproperty
	a_lock_pin: assert property (p_lock_pin) else $error("lock pin off lock");
	property p_free_flag;
		freeRunMode == (dpllState == dmsm_pkg::ST_FREE);
	endproperty
	a_free_flag: assert property (p_free_flag) else $error("free flag");
	property p_hold_flag;
		holdoverMode == (dpllState == dmsm_pkg::ST_HOLD);
	endproperty
	a_hold_flag: assert property (p_hold_flag) else $error("hold flag");
	property p_reset_free;
		$rose(resetn) |-> freeRunMode && dpllState == dmsm_pkg::ST_FREE;
	endproperty
	a_reset_free: assert property (p_reset_free) else $error("not free");
	// Transitions bounded to a few edges; causes of lock entry, freeze and mini-holdover
	property p_free_pre;
		freeRunMode && $rose(|inputOk) |-> ##[1:3] dpllState == dmsm_pkg::ST_PRE;
	endproperty
	a_free_pre: assert property (p_free_pre) else $error("no prelock");
	property p_hold_pre2;
		holdoverMode && $rose(|inputOk)
			|-> ##[1:3] dpllState == dmsm_pkg::ST_PRE2;
	endproperty
	a_hold_pre2: assert property (p_hold_pre2) else $error("hold stuck");
	property p_lol;
		dpllState == dmsm_pkg::ST_LOCKED && lossOfLock
			|-> ##[1:3] dpllState == dmsm_pkg::ST_LOL;
	endproperty
	a_lol: assert property (p_lol) else $error("no loss of lock");
	property p_lock_entry;
		$changed(dpllState) && dpllState == dmsm_pkg::ST_LOCKED
			|-> $past(phaseLocked, 2);
	endproperty
	a_lock_entry: assert property (p_lock_entry) else $error("early lock");
	property p_freeze;
		integralFreeze |-> $past(freqAtLimit);
	endproperty
	a_freeze: assert property (p_freeze) else $error("freeze no limit");
	property p_mini;
		$rose(miniHoldover) |-> $past(fastIsolate) || $past(fastIsolate, 2);
	endproperty
	a_mini: assert property (p_mini) else $error("mini no isolate");
	// Main scenarios
	c_locked: cover property (dpllState == dmsm_pkg::ST_LOCKED);
	c_lol: cover property (dpllState == dmsm_pkg::ST_LOL);
	c_hold: cover property (holdoverMode);
endmodule : dmsm_core_sva
bind dmsm_core dmsm_core_sva u_sva (.mclk(mclk), .resetn(resetn),
	.inputOk(inputOk), .phaseLocked(phaseLocked), .lossOfLock(lossOfLock),
	.fastIsolate(fastIsolate), .freqAtLimit(freqAtLimit), .lock_output_enable(lock_output_enable),
	.dpllState(dpllState), .freeRunMode(freeRunMode),
	.holdoverMode(holdoverMode), .miniHoldover(miniHoldover),
	.integralFreeze(integralFreeze));
`default_nettype wire

// File: dmsm_ref_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmsm_ref_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Scenario commands
	input wire logic [7:0] okCmd,
	input wire logic lockCmd,
	input wire logic lolCmd,
	input wire logic isoCmd,
	input wire logic limCmd,
	input wire logic [18:0] rateCmd,
	input wire logic [2:0] selectedRef,
	// Monitor and loop outputs
	output logic [7:0] inputOk,
	output logic phaseLocked,
	output logic lossOfLock,
	output logic fastIsolate,
	output logic freqAtLimit,
	output logic [18:0] integralRate
);
	// Monitors lag one edge; lock only holds on a live reference
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
		begin
			inputOk <= 8'h00;
			phaseLocked <= 1'b0;
			lossOfLock <= 1'b0;
			fastIsolate <= 1'b0;
			freqAtLimit <= 1'b0;
			integralRate <= 19'h00000;
		end
		else
		begin
			inputOk <= okCmd;
			phaseLocked <= lockCmd & okCmd[selectedRef];
			lossOfLock <= lolCmd;
			fastIsolate <= isoCmd;
			freqAtLimit <= limCmd;
			integralRate <= rateCmd;
		end
endmodule : dmsm_ref_model
`default_nettype wire

// File: dmsm_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dmsm_core_tb;
	localparam int TC = 10;
	localparam int SEC = 20 * TC;
	logic mclk = 1'b0, resetn = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
	logic [5:0] avsAddress = 6'h00;
	logic [31:0] avsWriteData = 32'h0, avsReadData, q;
	logic avsWaitRequest, phaseLocked, lossOfLock, fastIsolate, freqAtLimit;
	logic [7:0] inputOk, loopBandwidth, okCmd = 8'h00;
	logic lockCmd = 1'b0, lolCmd = 1'b0, isoCmd = 1'b0, limCmd = 1'b0;
	logic lock_output_enable, freeRunMode, holdoverMode, miniHoldover, integralFreeze;
	logic [2:0] dpllState, selectedRef;
	logic [18:0] integralRate, holdRate, rate = 19'h0, gap, man;
	logic [5:0] regA [6] = '{6'h00, 6'h04, 6'h10, 6'h14, 6'h1C, 6'h3C};
	int regV [6] = '{32'h001, 32'h064, 32'h10, 32'h08, 0, 0};
	int n_fail = 0, n_tests = 0, waited, seed;
	always #50 mclk = ~mclk;
	dmsm_core #(.TICK_CYC(TC)) u_dut (.mclk(mclk), .resetn(resetn),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .inputOk(inputOk),
		.phaseLocked(phaseLocked), .lossOfLock(lossOfLock),
		.fastIsolate(fastIsolate), .freqAtLimit(freqAtLimit),
		.integralRate(integralRate), .lock_output_enable(lock_output_enable),
		.dpllState(dpllState), .selectedRef(selectedRef),
		.freeRunMode(freeRunMode), .holdoverMode(holdoverMode),
		.miniHoldover(miniHoldover), .holdRate(holdRate),
		.loopBandwidth(loopBandwidth), .integralFreeze(integralFreeze));
	dmsm_ref_model u_model (.mclk(mclk), .resetn(resetn), .okCmd(okCmd),
		.lockCmd(lockCmd), .lolCmd(lolCmd), .isoCmd(isoCmd), .limCmd(limCmd),
		.rateCmd(rate), .selectedRef(selectedRef), .inputOk(inputOk),
		.phaseLocked(phaseLocked), .lossOfLock(lossOfLock),
		.fastIsolate(fastIsolate), .freqAtLimit(freqAtLimit),
		.integralRate(integralRate));
	////////////////////////////////////////////////////////////////////////
	// Verdict and run end
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	// Compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One bus cycle, held until waitrequest low
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		int i;
		@(posedge mclk);
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= wr;
		avsRead <= !wr;
		for (i = 0; i < 20; i++)
		begin
			@(posedge mclk);
			if (avsWaitRequest === 1'b0)
				break;
		end
		q = avsReadData;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		if (i == 20)
		begin
			n_fail++;
			close_out();
		end
	endtask : bus
	// Bounded wait for a state code
	task automatic wait_st(input logic [2:0] s, input int lim);
		for (waited = 0; waited < lim && dpllState !== s; waited++)
			@(posedge mclk);
		chk(dpllState, s);
		if (waited == lim)
			close_out();
	endtask : wait_st
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		seed = 32'hDE89;
		rate <= 19'($random(seed));
		gap = 19'($random(seed));
		man = 19'($random(seed));
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		chk(freeRunMode, 1);
		chk(loopBandwidth, 8'h08);
		foreach (regA[i])
		begin
			bus(1'b0, regA[i], 32'h0);
			chk(q, regV[i]);
		end
		bus(1'b1, dmsm_pkg::OFS_CTRL, 32'h183);
		bus(1'b1, dmsm_pkg::OFS_TIMEOUT, 32'h3);
		bus(1'b1, dmsm_pkg::OFS_GAP_RATE, 32'(gap));
		chk(loopBandwidth, 8'h10);
		okCmd <= 8'h04;
		wait_st(dmsm_pkg::ST_PRE, 10);
		chk(selectedRef, 3'd2);
		okCmd <= 8'h05;
		repeat (6) @(posedge mclk);
		chk(selectedRef, 3'd0);
		lockCmd <= 1'b1;
		wait_st(dmsm_pkg::ST_LOCKED, 4 * SEC);
		chk(32'(waited >= SEC), 1);
		chk(lock_output_enable, 1);
		chk(loopBandwidth, 8'h08);
		limCmd <= 1'b1;
		isoCmd <= 1'b1;
		repeat (6) @(posedge mclk);
		chk(integralFreeze, 1);
		chk(miniHoldover, 1);
		chk(holdRate, gap);
		limCmd <= 1'b0;
		isoCmd <= 1'b0;
		repeat (6) @(posedge mclk);
		chk(miniHoldover, 0);
		bus(1'b1, dmsm_pkg::OFS_EVENTS, 32'h7);
		lolCmd <= 1'b1;
		lockCmd <= 1'b0;
		wait_st(dmsm_pkg::ST_LOL, 10);
		bus(1'b0, dmsm_pkg::OFS_EVENTS, 32'h0);
		chk(q[0], 1);
		lolCmd <= 1'b0;
		lockCmd <= 1'b1;
		wait_st(dmsm_pkg::ST_LOCKED, 4 * SEC);
		okCmd <= 8'h00;
		wait_st(dmsm_pkg::ST_HOLD, 4 * SEC);
		chk(holdRate, rate);
		lockCmd <= 1'b0;
		okCmd <= 8'h02;
		wait_st(dmsm_pkg::ST_PRE2, 10);
		chk(selectedRef, 3'd1);
		wait_st(dmsm_pkg::ST_HOLD, 8 * SEC);
		bus(1'b0, dmsm_pkg::OFS_ALARM, 32'h0);
		chk(q, 32'h2);
		bus(1'b0, dmsm_pkg::OFS_VALID, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, dmsm_pkg::OFS_ALARM, 32'h2);
		wait_st(dmsm_pkg::ST_PRE2, 10);
		// Manual word set before entry, rate is latched then
		bus(1'b1, dmsm_pkg::OFS_HOLD_RATE, 32'(man));
		bus(1'b1, dmsm_pkg::OFS_CTRL, 32'h193);
		okCmd <= 8'h00;
		wait_st(dmsm_pkg::ST_HOLD, 4 * SEC);
		chk(holdoverMode, 1);
		chk(holdRate, man);
		bus(1'b0, dmsm_pkg::OFS_HOLD_RATE, 32'h0);
		chk(q, 32'(man));
		// Average of a constant locked rate is that rate
		bus(1'b1, dmsm_pkg::OFS_CTRL, 32'h1D3);
		bus(1'b0, dmsm_pkg::OFS_HOLD_RATE, 32'h0);
		chk(q, 32'(rate));
		bus(1'b1, dmsm_pkg::OFS_FORCE, 32'h0);
		wait_st(dmsm_pkg::ST_FREE, 10);
		okCmd <= 8'h01;
		wait_st(dmsm_pkg::ST_PRE, 10);
		wait_st(dmsm_pkg::ST_FREE, 8 * SEC);
		bus(1'b0, dmsm_pkg::OFS_ALARM, 32'h0);
		chk(q, 32'h1);
		// Mid-run reset restores control defaults
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		bus(1'b0, dmsm_pkg::OFS_CTRL, 32'h0);
		chk(q, 32'h1);
		close_out();
	end
endmodule : dmsm_core_tb
`default_nettype wire
